// [pkg/fcs_pkg.sv]
// Package: constants and types of the follower clutch state machine
`default_nettype none
package fcs_pkg;
   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRE1 = 8'h01;
   localparam logic [7:0] OFS_PRE2 = 8'h02;
   localparam logic [7:0] OFS_STAT = 8'h03;
   localparam logic [7:0] OFS_IST = 8'h04;
   localparam logic [7:0] OFS_IMSK = 8'h05;
   // Remaining lead count, monitor index 61 decimal
   localparam logic [7:0] OFS_LEAD = 8'h3D;
   // Control word field positions
   localparam int EN_POS = 0;
   localparam int ENG_POS = 4;
   localparam int DIS_POS = 12;
   // Engage condition codes
   localparam logic [2:0] ENG_IMM = 3'h0;
   localparam logic [2:0] ENG_DI = 3'h1;
   localparam logic [2:0] ENG_CAP = 3'h2;
   // Disengage condition codes
   localparam logic [2:0] DIS_NONE = 3'h0;
   localparam logic [2:0] DIS_DI = 3'h1;
   localparam logic [2:0] DIS_CNT = 3'h2;
   localparam logic [2:0] DIS_RELEAD = 3'h4;
   localparam logic [2:0] DIS_EXT = 3'h6;
   // Interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_ENG = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_OVF = 2;
   // Values after reset
   localparam logic [31:0] RST_PRE = 32'h0000_0000;
   localparam logic [2:0] RST_MSK = 3'h0;
   typedef enum logic [1:0] {
      ST_STOP,
      ST_LEAD,
      ST_ENG
   } fcs_state_t;
   typedef struct packed {
      logic [2:0] dis;
      logic [2:0] eng;
      logic en;
   } fcs_ctrl_t;
   localparam fcs_ctrl_t RST_CTRL = '{dis: 3'h0, eng: 3'h0, en: 1'b0};
endpackage : fcs_pkg
`default_nettype wire

// [core/fcs_clutch.sv]
// Module: follower clutch state machine with register port and interrupt
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////
// Summary of operation
// - Three states; Stop at reset ignores pulses
// - Enable defaults off; clearing forces disengage
// - Lead Pulse: pulses only feed lead count
// - Engage condition: Stop to Lead, load preset
// - Code 0 engages once enabled
// - Code 1 engages on clutch input on
// - Code 2 engages with next capture
// - Forward pulses count lead down, reverse up; zero engages
// - Zero preset engages without pulses
// - Preset sign gives expected master direction
// - Engaged follower moves with every pulse
// - Code 4 disengage reloads re-engage preset
// - Codes 1, 2, 6 disengage to Stop
// - Clearing enable returns to Stop always
// - Remaining lead count always readable
// - Lead overflow clears enable, forces Stop
// - Code 0 never disengages; 1 on input off
module fcs_clutch #(
   parameter int CNT_W = 32
) (
   input wire logic sys_clk_i, // System clock, 20 MHz
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic [7:0] addr_i, // Register address
   input wire logic [31:0] wdata_i, // Register write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   input wire logic mpulse_i, // Master axis pulse, one cycle
   input wire logic mdir_i, // Master direction, 1 reverse
   input wire logic clutch_di_i, // Clutch digital input
   input wire logic capture_i, // Position capture event
   input wire logic disen_evt_i, // Disengage event, codes 2/4/6
   output logic [31:0] rdata_o, // Read data, cycle after strobe
   output fcs_pkg::fcs_state_t state_o, // Clutch state
   output logic follow_pulse_o, // Pulse passed to follower
   output logic follow_dir_o, // Direction of follower pulse
   output logic irq_o // Interrupt, level
);

   // Lead counter needs a sign bit and a magnitude bit, and must fit a data word
   if (CNT_W < 2 || CNT_W > fcs_pkg::DATA_W) begin : g_bad_cnt_w
      $error("CNT_W must lie between 2 and 32");
   end

   localparam logic signed [CNT_W-1:0] CMAX = {1'b0, {(CNT_W-1){1'b1}}};
   localparam logic signed [CNT_W-1:0] CMIN = {1'b1, {(CNT_W-1){1'b0}}};

   function automatic logic [31:0] ext_w(input logic signed [CNT_W-1:0] v);
      ext_w = 32'(v);
   endfunction : ext_w

   //////////////////////////////////////////////////////////////////
   // Registers and next values

   fcs_pkg::fcs_state_t st_q, st_d;
   fcs_pkg::fcs_ctrl_t ctrl_q;
   logic signed [CNT_W-1:0] pre1_q, pre2_q, lead_q, lead_d, lead_nx;
   logic [2:0] ist_q, msk_q, ev_d;
   logic ovf_d;
   logic eng_cond, dis_stop, dis_rel, wr_ctrl, rd_ist, clr_en, run_en;

   assign wr_ctrl = wr_i && addr_i == fcs_pkg::OFS_CTRL;
   assign rd_ist = rd_i && addr_i == fcs_pkg::OFS_IST;
   // clearing write acts on its own edge
   // Waiting for the stored bit would let a same-cycle event slip through first
   assign clr_en = wr_ctrl && !wdata_i[fcs_pkg::EN_POS];
   assign run_en = ctrl_q.en && !clr_en;

   //////////////////////////////////////////////////////////////////
   // Condition decode

   always_comb begin
      eng_cond = 1'b0;
      case (ctrl_q.eng)
         fcs_pkg::ENG_IMM: eng_cond = 1'b1;
         fcs_pkg::ENG_DI: eng_cond = clutch_di_i;
         fcs_pkg::ENG_CAP: eng_cond = capture_i;
         default: eng_cond = 1'b0;
      endcase
   end

   always_comb begin
      dis_stop = 1'b0;
      dis_rel = 1'b0;
      case (ctrl_q.dis)
         fcs_pkg::DIS_DI: dis_stop = !clutch_di_i;
         fcs_pkg::DIS_CNT: dis_stop = disen_evt_i;
         fcs_pkg::DIS_EXT: dis_stop = disen_evt_i;
         fcs_pkg::DIS_RELEAD: dis_rel = disen_evt_i;
         default: begin
            dis_stop = 1'b0;
            dis_rel = 1'b0;
         end
      endcase
   end

   // forward pulse counts down, reverse counts up
   assign lead_nx = mdir_i ? lead_q + CNT_W'(1) : lead_q - CNT_W'(1);

   //////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_d = st_q;
      lead_d = lead_q;
      ovf_d = 1'b0;
      ev_d = 3'h0;
      if (!run_en) begin
         st_d = fcs_pkg::ST_STOP;
         if (st_q == fcs_pkg::ST_ENG) begin
            ev_d[fcs_pkg::IRQ_STOP] = 1'b1;
         end
      end else begin
         case (st_q)
            fcs_pkg::ST_STOP: begin
               if (eng_cond) begin
                  lead_d = pre1_q;
                  if (pre1_q == '0) begin
                     st_d = fcs_pkg::ST_ENG;
                     ev_d[fcs_pkg::IRQ_ENG] = 1'b1;
                  end else begin
                     st_d = fcs_pkg::ST_LEAD;
                  end
               end
            end
            fcs_pkg::ST_LEAD: begin
               if (mpulse_i) begin
                  if ((mdir_i && lead_q == CMAX) || (!mdir_i && lead_q == CMIN)) begin
                     ovf_d = 1'b1;
                     st_d = fcs_pkg::ST_STOP;
                     ev_d[fcs_pkg::IRQ_OVF] = 1'b1;
                  end else begin
                     lead_d = lead_nx;
                     if (lead_nx == '0) begin
                        st_d = fcs_pkg::ST_ENG;
                        ev_d[fcs_pkg::IRQ_ENG] = 1'b1;
                     end
                  end
               end else if (lead_q == '0) begin
                  st_d = fcs_pkg::ST_ENG;
                  ev_d[fcs_pkg::IRQ_ENG] = 1'b1;
               end
            end
            fcs_pkg::ST_ENG: begin
               if (dis_stop) begin
                  st_d = fcs_pkg::ST_STOP;
                  ev_d[fcs_pkg::IRQ_STOP] = 1'b1;
               end else if (dis_rel) begin
                  lead_d = pre2_q;
                  if (pre2_q != '0) begin
                     st_d = fcs_pkg::ST_LEAD;
                  end
               end
            end
            default: st_d = fcs_pkg::ST_STOP;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////
   // State and lead counter

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_q <= fcs_pkg::ST_STOP;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         lead_q <= '0;
      end else begin
         lead_q <= lead_d;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Follower pulse output

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         follow_pulse_o <= 1'b0;
         follow_dir_o <= 1'b0;
      end else begin
         // Engaged passes every pulse; others block
         follow_pulse_o <= mpulse_i && st_q == fcs_pkg::ST_ENG;
         follow_dir_o <= mdir_i;
      end
   end

   assign state_o = st_q;

   //////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_q <= fcs_pkg::RST_CTRL;
      end else begin
         if (wr_ctrl) begin
            ctrl_q.en <= wdata_i[fcs_pkg::EN_POS];
            ctrl_q.eng <= wdata_i[fcs_pkg::ENG_POS +: 3];
            ctrl_q.dis <= wdata_i[fcs_pkg::DIS_POS +: 3];
         end
         // overflow clears enable; beats software set
         if (ovf_d) begin
            ctrl_q.en <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pre1_q <= CNT_W'(fcs_pkg::RST_PRE);
         pre2_q <= CNT_W'(fcs_pkg::RST_PRE);
         msk_q <= fcs_pkg::RST_MSK;
      end else if (wr_i) begin
         if (addr_i == fcs_pkg::OFS_PRE1) begin
            pre1_q <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == fcs_pkg::OFS_PRE2) begin
            pre2_q <= wdata_i[CNT_W-1:0];
         end
         if (addr_i == fcs_pkg::OFS_IMSK) begin
            msk_q <= wdata_i[fcs_pkg::IRQ_W-1:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // Interrupt status: read clears, a new event wins

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ist_q <= 3'h0;
      end else begin
         ist_q <= (rd_ist ? 3'h0 : ist_q) | ev_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((rd_ist ? 3'h0 : ist_q) | ev_d) & msk_q);
      end
   end

   //////////////////////////////////////////////////////////////////
   // Read port; unmapped reads return zero

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            fcs_pkg::OFS_CTRL: rdata_o <= 32'({ctrl_q.dis, 5'h00, ctrl_q.eng, 3'h0, ctrl_q.en});
            fcs_pkg::OFS_PRE1: rdata_o <= ext_w(pre1_q);
            fcs_pkg::OFS_PRE2: rdata_o <= ext_w(pre2_q);
            fcs_pkg::OFS_STAT: rdata_o <= 32'(st_q);
            fcs_pkg::OFS_IST: rdata_o <= 32'(ist_q);
            fcs_pkg::OFS_IMSK: rdata_o <= 32'(msk_q);
            fcs_pkg::OFS_LEAD: rdata_o <= ext_w(lead_q);
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_stop_ignores: assert property (
      st_q != fcs_pkg::ST_ENG |=> !follow_pulse_o)
      else $error("follower pulse outside Engaged");

   a_disable_stop: assert property (
      !ctrl_q.en |=> st_q == fcs_pkg::ST_STOP)
      else $error("disabled clutch not in Stop");

   a_engage_load: assert property (
      st_q == fcs_pkg::ST_STOP && run_en && eng_cond && pre1_q != '0
      |=> st_q == fcs_pkg::ST_LEAD && lead_q == $past(pre1_q))
      else $error("engage did not load first preset");

   a_imm_engage: assert property (
      st_q == fcs_pkg::ST_STOP && run_en && ctrl_q.eng == fcs_pkg::ENG_IMM
      |=> st_q != fcs_pkg::ST_STOP)
      else $error("immediate engage missed");

   a_di_engage: assert property (
      st_q == fcs_pkg::ST_STOP && ctrl_q.eng == fcs_pkg::ENG_DI && !clutch_di_i
      |=> st_q == fcs_pkg::ST_STOP)
      else $error("engaged without clutch input");

   a_cap_engage: assert property (
      st_q == fcs_pkg::ST_STOP && ctrl_q.eng == fcs_pkg::ENG_CAP && !capture_i
      |=> st_q == fcs_pkg::ST_STOP)
      else $error("engaged without capture");

   a_lead_count: assert property (
      st_q == fcs_pkg::ST_LEAD && run_en && mpulse_i && !mdir_i && lead_q == CNT_W'(1)
      |=> st_q == fcs_pkg::ST_ENG ##1 (st_q == fcs_pkg::ST_ENG || $past(!run_en || dis_stop || dis_rel)))
      else $error("lead count reached zero without engage");

   a_zero_preset: assert property (
      st_q == fcs_pkg::ST_STOP && run_en && eng_cond && pre1_q == '0
      |=> st_q == fcs_pkg::ST_ENG)
      else $error("zero preset did not engage");

   a_follow_pass: assert property (
      st_q == fcs_pkg::ST_ENG && mpulse_i |=> follow_pulse_o && follow_dir_o == $past(mdir_i))
      else $error("Engaged pulse lost");

   a_reengage: assert property (
      st_q == fcs_pkg::ST_ENG && run_en && ctrl_q.dis == fcs_pkg::DIS_RELEAD && disen_evt_i
      && pre2_q != '0 |=> st_q == fcs_pkg::ST_LEAD && lead_q == $past(pre2_q))
      else $error("re-engage preset not loaded");

   a_dis_stop: assert property (
      st_q == fcs_pkg::ST_ENG && run_en && dis_stop |=> st_q == fcs_pkg::ST_STOP)
      else $error("disengage to Stop missed");

   a_ovf_stop: assert property (
      ovf_d |=> st_q == fcs_pkg::ST_STOP && !ctrl_q.en)
      else $error("overflow did not stop");

   a_clear_first: assert property (
      clr_en |=> st_q == fcs_pkg::ST_STOP && !ctrl_q.en)
      else $error("enable clear did not win");

   a_irq_level: assert property (
      |(ist_q & msk_q) |-> ##[0:1] irq_o)
      else $error("masked status not raised");

   c_engage_lead: cover property (st_q == fcs_pkg::ST_LEAD ##[1:20] st_q == fcs_pkg::ST_ENG);
   c_reengage: cover property (st_q == fcs_pkg::ST_ENG ##1 st_q == fcs_pkg::ST_LEAD);
   c_overflow: cover property (ovf_d);
   c_dis_stop: cover property (st_q == fcs_pkg::ST_ENG ##1 st_q == fcs_pkg::ST_STOP);
   c_clear_engaged: cover property (st_q == fcs_pkg::ST_ENG && clr_en);

endmodule : fcs_clutch

`default_nettype wire

// [test/fcs_master_src.sv]
// Master axis pulse source model for the clutch bench
`timescale 1ns/10ps
`default_nettype none
module fcs_master_src (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_i, // Reset, active high
   input wire logic start_i, // Start a burst
   input wire logic [7:0] num_i, // Pulses in the burst
   input wire logic dir_i, // Burst direction, 1 reverse
   input wire logic slow_i, // Idle cycle between pulses
   output logic mpulse_o, // Master pulse
   output logic mdir_o, // Direction beside the pulse
   output logic busy_o // Burst running
);
   logic [7:0] left_q;
   logic gap_q;
   logic slow_q;
   logic dir_q;
   logic tog_q;
   ////////////////////////////////////////
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         left_q <= 8'h00;
         gap_q <= 1'b0;
         slow_q <= 1'b0;
         dir_q <= 1'b0;
      end else if (start_i) begin
         left_q <= num_i;
         gap_q <= 1'b0;
         slow_q <= slow_i;
         dir_q <= dir_i;
      end else if (left_q != 8'h00) begin
         if (gap_q) begin
            gap_q <= 1'b0;
         end else begin
            left_q <= left_q - 8'h01;
            gap_q <= slow_q;
         end
      end
   end
   // Direction wanders between pulses, so a misread shows up
   always_ff @(posedge sys_clk_i) begin
      tog_q <= rst_i ? 1'b0 : ~tog_q;
   end
   assign mpulse_o = (left_q != 8'h00) && !gap_q;
   assign mdir_o = mpulse_o ? dir_q : tog_q;
   assign busy_o = left_q != 8'h00;
endmodule : fcs_master_src
`default_nettype wire

// [test/tb_follower_clutch_state_machine.sv]
// Self-checking bench of the follower clutch state machine
`timescale 1ns/10ps
`default_nettype none
module tb_follower_clutch_state_machine;
   logic sys_clk, rst, wr, rd, cdi, cap, dev, mst, mdir_req, mslow, mpulse, mdir, mbusy, fpulse, fdir, irq;
   logic [7:0] addr, mnum;
   logic [31:0] wdata, rdata, v;
   fcs_pkg::fcs_state_t state;
   int num_errors = 0;
   int num_checks = 0;
   int fcnt = 0;
   int frev = 0;
   int cyc = 0;
   // Narrow counter keeps the overflow walk short
   fcs_clutch #(.CNT_W(4)) u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .mpulse_i(mpulse), .mdir_i(mdir), .clutch_di_i(cdi), .capture_i(cap),
      .disen_evt_i(dev), .rdata_o(rdata), .state_o(state), .follow_pulse_o(fpulse),
      .follow_dir_o(fdir), .irq_o(irq));
   fcs_master_src u_src (.sys_clk_i(sys_clk), .rst_i(rst), .start_i(mst), .num_i(mnum), .dir_i(mdir_req),
      .slow_i(mslow), .mpulse_o(mpulse), .mdir_o(mdir), .busy_o(mbusy));
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (fpulse === 1'b1) fcnt++;
      if (fpulse === 1'b1 && fdir === 1'b1) frev++;
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   task close_out;
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task chk_st(input logic [1:0] e);
      chk({30'h0, state}, {30'h0, e});
   endtask : chk_st
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_clk
   task burst(input logic [7:0] n, input logic d, input logic s);
      int i;
      i = 0;
      @(posedge sys_clk);
      mst <= 1'b1;
      mnum <= n;
      mdir_req <= d;
      mslow <= s;
      @(posedge sys_clk);
      mst <= 1'b0;
      #1;
      while (mbusy === 1'b1 && i < 600) begin
         wait_clk(1);
         i++;
      end
   endtask : burst
   task evt(input logic c);
      @(posedge sys_clk);
      cap <= c;
      dev <= !c;
      @(posedge sys_clk);
      cap <= 1'b0;
      dev <= 1'b0;
   endtask : evt
   function automatic logic [31:0] ctl(input logic en, input logic [2:0] eng, input logic [2:0] dis);
      return {17'h0, dis, 5'h0, eng, 3'h0, en};
   endfunction : ctl
   ////////////////////////////////////////
   task t_reset;
      chk_st(fcs_pkg::ST_STOP);
      rd_reg(fcs_pkg::OFS_CTRL, v);
      chk(v, 32'h0);
      rd_reg(8'h7F, v);
      chk(v, 32'h0);
      fcnt = 0;
      burst(8'h02, 1'b0, 1'b0);
      wait_clk(2);
      chk(fcnt, 32'h0);
      chk_st(fcs_pkg::ST_STOP);
   endtask : t_reset
   task t_lead;
      wr_reg(fcs_pkg::OFS_PRE1, 32'h3);
      wr_reg(fcs_pkg::OFS_IMSK, 32'h1);
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h0, 3'h0));
      wait_clk(2);
      chk_st(fcs_pkg::ST_LEAD);
      rd_reg(fcs_pkg::OFS_LEAD, v);
      chk(v, 32'h3);
      fcnt = 0;
      burst(8'h03, 1'b0, 1'b1);
      wait_clk(2);
      chk_st(fcs_pkg::ST_ENG);
      chk(fcnt, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd_reg(fcs_pkg::OFS_IST, v);
      chk(v, 32'h1);
      wait_clk(2);
      chk({31'h0, irq}, 32'h0);
      fcnt = 0;
      frev = 0;
      burst(8'h04, 1'b1, 1'b0);
      wait_clk(2);
      chk(fcnt, 32'h4);
      chk(frev, 32'h4);
      wr_reg(fcs_pkg::OFS_CTRL, 32'h0);
      wait_clk(1);
      chk_st(fcs_pkg::ST_STOP);
      rd_reg(fcs_pkg::OFS_IST, v);
      chk(v, 32'h2);
   endtask : t_lead
   task t_codes;
      wr_reg(fcs_pkg::OFS_PRE1, 32'h0);
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h0, 3'h0));
      wait_clk(3);
      chk_st(fcs_pkg::ST_ENG);
      evt(1'b0);
      wait_clk(2);
      chk_st(fcs_pkg::ST_ENG);
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h1, 3'h1));
      wait_clk(3);
      chk_st(fcs_pkg::ST_STOP);
      @(posedge sys_clk);
      cdi <= 1'b1;
      wait_clk(3);
      chk_st(fcs_pkg::ST_ENG);
      @(posedge sys_clk);
      cdi <= 1'b0;
      wait_clk(2);
      chk_st(fcs_pkg::ST_STOP);
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h2, 3'h2));
      wait_clk(3);
      chk_st(fcs_pkg::ST_STOP);
      evt(1'b1);
      wait_clk(2);
      chk_st(fcs_pkg::ST_ENG);
      evt(1'b0);
      wait_clk(2);
      chk_st(fcs_pkg::ST_STOP);
      wr_reg(fcs_pkg::OFS_CTRL, 32'h0);
      // Capture engage, so the Stop after the event is not left again at once
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h2, 3'h6));
      evt(1'b1);
      wait_clk(2);
      chk_st(fcs_pkg::ST_ENG);
      evt(1'b0);
      wait_clk(2);
      chk_st(fcs_pkg::ST_STOP);
      wr_reg(fcs_pkg::OFS_CTRL, 32'h0);
   endtask : t_codes
   task t_reload;
      wr_reg(fcs_pkg::OFS_PRE2, 32'h2);
      wr_reg(fcs_pkg::OFS_CTRL, ctl(1'b1, 3'h0, 3'h4));
      wait_clk(3);
      evt(1'b0);
      wait_clk(2);
      chk_st(fcs_pkg::ST_LEAD);
      rd_reg(fcs_pkg::OFS_LEAD, v);
      chk(v, 32'h2);
      burst(8'h02, 1'b0, 1'b1);
      wait_clk(2);
      chk_st(fcs_pkg::ST_ENG);
      // Enable clear and reload event land on one edge
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= fcs_pkg::OFS_CTRL;
      wdata <= 32'h0;
      dev <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      dev <= 1'b0;
      #1;
      chk_st(fcs_pkg::ST_STOP);
      wait_clk(2);
      chk_st(fcs_pkg::ST_STOP);
   endtask : t_reload
   task t_ovf;
      rd_reg(fcs_pkg::OFS_IST, v);
      wr_reg(fcs_pkg::OFS_PRE1, 32'h2);
      wr_reg(fcs_pkg::OFS_IMSK, 32'h4);
      wr_reg(fcs_pkg::OFS_CTRL, 32'h1);
      wait_clk(2);
      burst(8'h08, 1'b1, 1'b0);
      wait_clk(2);
      chk_st(fcs_pkg::ST_STOP);
      rd_reg(fcs_pkg::OFS_CTRL, v);
      chk(v, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd_reg(fcs_pkg::OFS_IST, v);
      chk(v, 32'h4);
   endtask : t_ovf
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {wr, rd, cdi, cap, dev, mst, mdir_req, mslow} = 8'h00;
      addr = 8'h00;
      mnum = 8'h00;
      wdata = 32'h0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      wait_clk(1);
      t_reset();
      t_lead();
      t_codes();
      t_reload();
      t_ovf();
      close_out();
   end
endmodule : tb_follower_clutch_state_machine
`default_nettype wire
